// file: rtl/clock_config_ctrl.sv
// Configuration and control of a three-PLL clock generator: frequency table, crosspoint,
// output dividers, load-capacitance code and power management.
// Assumes source edges arrive as one-cycle ticks synchronous to sys_clk_i; the analog PLLs
// and pads sit outside and follow pll_cfg_o, osc_run_o and the output enables.
`timescale 1ns/10ps

module clock_config_ctrl
  import clk_cfg_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic     [7:0]       reg_addr_i,
  input  wire logic     [7:0]       reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic          [7:0]       reg_rdata_o,
  input  wire logic                 freq_select_bit0_i,
  input  wire logic                 freq_select_bit1_i,
  input  wire logic                 freq_select_bit2_i,
  input  wire logic                 shutdown_oe_i,
  input  wire logic     [3:0]       src_tick_i,
  output pll_cfg_t      [2:0]       pll_cfg_o,
  output logic          [5:0]       crystal_load_code_o,
  output logic                      osc_run_o,
  output logic          [4:0]       clk_out_o,
  output logic          [4:0]       clk_oe_o,
  output logic          [2:0]       table_row_o
);

  state_t           s_q;
  state_t           s_d;
  row_t             cur_row;
  logic [2:0]       row_idx;
  logic             tri_all;
  logic             full_sd;
  logic             susp_act;
  logic             osc_ok;
  logic [2:0]       pll_live;
  logic [2:0]       fs_k;
  logic             live_k;
  logic             tick_k;
  logic [2:0]       div_idx;
  logic [6:0]       div_k;
  logic [6:0]       half_k;
  logic [1:0]       e_code;
  logic [1:0]       e_mod;
  logic             e_tick;
  logic [2:0]       tbl_row;
  logic             tbl_hit;
  logic             pll_hit;

  always_comb begin
    s_d      = s_q;
    cur_row  = '0;
    row_idx  = 3'h0;
    tri_all  = 1'b0;
    full_sd  = 1'b0;
    susp_act = 1'b0;
    osc_ok   = 1'b0;
    pll_live = 3'h0;
    fs_k     = 3'h0;
    live_k   = 1'b0;
    tick_k   = 1'b0;
    div_idx  = 3'h0;
    div_k    = 7'h00;
    half_k   = 7'h00;
    e_code   = 2'h0;
    e_mod    = 2'h0;
    e_tick   = 1'b0;
    tbl_row  = reg_addr_i[4:2];
    tbl_hit  = (reg_addr_i[7:5] == ADDR_TBL_TOP) && (reg_addr_i[1:0] != 2'h3);
    pll_hit  = (reg_addr_i[7:3] == ADDR_PLL2_Q[7:3]) && (reg_addr_i[1:0] != 2'h3);

    // Levels of select pins 0 and 1 caught once, on the first edge after reset release
    if (!s_q.strap_done) begin
      s_d.strap      = {freq_select_bit1_i, freq_select_bit0_i};
      s_d.strap_done = 1'b1;
    end

    // In suspend mode the third pin belongs to suspend, so it no longer indexes the table
    row_idx = {(s_q.ctrl[CTRL_SUSP_MODE] ? 1'b0 : freq_select_bit2_i), s_q.strap};
    cur_row = s_q.tbl[row_idx];

    tri_all  = !shutdown_oe_i;
    full_sd  = tri_all && s_q.ctrl[CTRL_SD_FUNC];
    susp_act = s_q.ctrl[CTRL_SUSP_MODE] && !freq_select_bit2_i;
    osc_ok   = !full_sd;

    for (int i = 0; i < 3; i++) begin
      pll_live[i] = s_q.ctrl[CTRL_PLL_EN0 + i] && !full_sd
                    && !(susp_act && s_q.susp[i]);
    end

    // Outputs A-D: crosspoint, 7-bit divider, phase choice
    for (int k = 0; k < 4; k++) begin
      fs_k = s_q.fs[k];
      if (fs_k == FS_REF) begin
        live_k = osc_ok;
      end else if (fs_k == FS_RSVD) begin
        live_k = 1'b0;
      end else begin
        live_k = pll_live[fs_k[2:1] - 2'h1];
      end
      if (k < 2) begin
        div_idx = 3'(2 * k) + {2'h0, s_q.ab_sel[k]};
      end else begin
        div_idx = 3'(k + 2);
      end
      // Live register value, no sync to the output: a write lands mid-period
      div_k  = s_q.div[div_idx];
      tick_k = src_tick_i[fs_k[2:1]] && live_k && (div_k != 7'h00);
      if (tick_k) begin
        if (s_q.cnt[k] >= div_k - 7'h01) begin
          s_d.cnt[k] = 7'h00;
          // Pin-driven select change lands at a period boundary, or at once while the selected divider is zero
          if (k < 2) begin
            s_d.ab_sel[k] = cur_row.ab_divider_register_select;
          end
        end else begin
          s_d.cnt[k] = s_q.cnt[k] + 7'h01;
        end
      end else if ((k < 2) && (div_k == 7'h00)) begin
        s_d.ab_sel[k] = cur_row.ab_divider_register_select;
      end
      half_k       = 7'((8'(div_k) + 8'h01) >> 1);
      s_d.clk[k]   = (s_q.cnt[k] < half_k) ^ fs_k[0];
      // An output's suspend bit only gates the pad; the divider keeps counting while its source is live
      s_d.oe[k]    = live_k && (div_k != 7'h00) && !s_q.out_dis[k]
                     && !(susp_act && s_q.susp[SUSP_OUT0 + k]) && !tri_all;
    end

    // Output E: PLL1 through the small post-divider
    e_code = s_q.ctrl[CTRL_E_DIV_LO +: 2];
    unique case (e_code)
      E_DIV4:  e_mod = E_MOD4;
      E_DIV2:  e_mod = E_MOD2;
      E_DIV3:  e_mod = E_MOD3;
      E_OFF:   e_mod = 2'h0;
    endcase
    e_tick = src_tick_i[1] && pll_live[0] && (e_code != E_OFF);
    if (e_tick) begin
      s_d.ecnt = (s_q.ecnt >= e_mod) ? 2'h0 : s_q.ecnt + 2'h1;
    end
    // Three bits wide: in two bits the /4 half count wraps to zero
    s_d.clk[4] = ({1'b0, s_q.ecnt} < (({1'b0, e_mod} + 3'h1) >> 1));
    s_d.oe[4]  = pll_live[0] && (e_code != E_OFF) && !s_q.out_dis[4]
                 && !(susp_act && s_q.susp[SUSP_OUT0 + 4]) && !tri_all;

    // PLL settings to the analog side; PLL1 follows the pin-selected row
    s_d.pll_o[0].en = pll_live[0];
    s_d.pll_o[0].p  = cur_row.p;
    s_d.pll_o[0].q  = cur_row.q;
    for (int i = 1; i < 3; i++) begin
      s_d.pll_o[i].en = pll_live[i];
      s_d.pll_o[i].p  = s_q.pll23[i - 1].p;
      s_d.pll_o[i].q  = s_q.pll23[i - 1].q;
    end
    s_d.xcap_o  = s_q.xcap;
    s_d.osc_run = osc_ok;
    s_d.row_o   = row_idx;

    // Register port stays live under shutdown: it runs on sys_clk only
    if (reg_wr_i) begin
      if (tbl_hit) begin
        unique case (reg_addr_i[1:0])
          TBL_BYTE_Q:   s_d.tbl[tbl_row].q = reg_wdata_i;
          TBL_BYTE_PLO: s_d.tbl[tbl_row].p[7:0] = reg_wdata_i;
          default: begin
            s_d.tbl[tbl_row].p[10:8] = reg_wdata_i[2:0];
            s_d.tbl[tbl_row].ab_divider_register_select  = reg_wdata_i[PHI_SEL_BIT];
          end
        endcase
      end else if (pll_hit) begin
        unique case (reg_addr_i[1:0])
          TBL_BYTE_Q:   s_d.pll23[reg_addr_i[2]].q = reg_wdata_i;
          TBL_BYTE_PLO: s_d.pll23[reg_addr_i[2]].p[7:0] = reg_wdata_i;
          default:      s_d.pll23[reg_addr_i[2]].p[10:8] = reg_wdata_i[2:0];
        endcase
      end else begin
        unique case (reg_addr_i)
          ADDR_DIV_A0:    s_d.div[0] = reg_wdata_i[6:0];
          ADDR_DIV_A1:    s_d.div[1] = reg_wdata_i[6:0];
          ADDR_DIV_B0:    s_d.div[2] = reg_wdata_i[6:0];
          ADDR_DIV_B1:    s_d.div[3] = reg_wdata_i[6:0];
          ADDR_DIV_C:     s_d.div[4] = reg_wdata_i[6:0];
          ADDR_DIV_D:     s_d.div[5] = reg_wdata_i[6:0];
          ADDR_SRC_AB: begin
            s_d.fs[0] = reg_wdata_i[2:0];
            s_d.fs[1] = reg_wdata_i[6:4];
          end
          ADDR_SRC_CD: begin
            s_d.fs[2] = reg_wdata_i[2:0];
            s_d.fs[3] = reg_wdata_i[6:4];
          end
          ADDR_CTRL:      s_d.ctrl    = reg_wdata_i;
          ADDR_XCAP:      s_d.xcap    = reg_wdata_i[5:0];
          ADDR_SUSP_MASK: s_d.susp    = reg_wdata_i;
          ADDR_OUT_DIS:   s_d.out_dis = reg_wdata_i[4:0];
          default: ;
        endcase
      end
    end

    // Read data stands only in the cycle after the strobe
    s_d.rdata = RDATA_UNMAP;
    if (reg_rd_i) begin
      if (tbl_hit) begin
        unique case (reg_addr_i[1:0])
          TBL_BYTE_Q:   s_d.rdata = s_q.tbl[tbl_row].q;
          TBL_BYTE_PLO: s_d.rdata = s_q.tbl[tbl_row].p[7:0];
          default:      s_d.rdata = {s_q.tbl[tbl_row].ab_divider_register_select, 4'h0, s_q.tbl[tbl_row].p[10:8]};
        endcase
      end else if (pll_hit) begin
        unique case (reg_addr_i[1:0])
          TBL_BYTE_Q:   s_d.rdata = s_q.pll23[reg_addr_i[2]].q;
          TBL_BYTE_PLO: s_d.rdata = s_q.pll23[reg_addr_i[2]].p[7:0];
          default:      s_d.rdata = {5'h00, s_q.pll23[reg_addr_i[2]].p[10:8]};
        endcase
      end else begin
        unique case (reg_addr_i)
          ADDR_DIV_A0:    s_d.rdata = {1'b0, s_q.div[0]};
          ADDR_DIV_A1:    s_d.rdata = {1'b0, s_q.div[1]};
          ADDR_DIV_B0:    s_d.rdata = {1'b0, s_q.div[2]};
          ADDR_DIV_B1:    s_d.rdata = {1'b0, s_q.div[3]};
          ADDR_DIV_C:     s_d.rdata = {1'b0, s_q.div[4]};
          ADDR_DIV_D:     s_d.rdata = {1'b0, s_q.div[5]};
          ADDR_SRC_AB:    s_d.rdata = {1'b0, s_q.fs[1], 1'b0, s_q.fs[0]};
          ADDR_SRC_CD:    s_d.rdata = {1'b0, s_q.fs[3], 1'b0, s_q.fs[2]};
          ADDR_CTRL:      s_d.rdata = s_q.ctrl;
          ADDR_XCAP:      s_d.rdata = {2'h0, s_q.xcap};
          ADDR_SUSP_MASK: s_d.rdata = s_q.susp;
          ADDR_OUT_DIS:   s_d.rdata = {3'h0, s_q.out_dis};
          ADDR_STATUS:    s_d.rdata = {1'b0, s_q.strap_done, susp_act, full_sd, tri_all, row_idx};
          default:        s_d.rdata = RDATA_UNMAP;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q         <= '0;
      s_q.ctrl    <= CTRL_RST;
      s_q.xcap    <= XCAP_RST;
      s_q.susp    <= SUSP_RST;
      s_q.out_dis <= OUT_DIS_RST;
      s_q.div     <= {6{DIV_RST}};
      s_q.fs      <= {4{FS_RST}};
      s_q.rdata   <= RDATA_UNMAP;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o         = s_q.rdata;
  assign pll_cfg_o           = s_q.pll_o;
  assign crystal_load_code_o = s_q.xcap_o;
  assign osc_run_o           = s_q.osc_run;
  assign clk_out_o           = s_q.clk;
  assign clk_oe_o            = s_q.oe;
  assign table_row_o         = s_q.row_o;

endmodule : clock_config_ctrl

// file: rtl/clk_cfg_pkg.sv
// Constants, register map and carrier types of the three-PLL clock configuration block.
// Assumes an 8-bit register port and one 10 MHz system clock.
package clk_cfg_pkg;

  // Register map: byte offsets on the plain register port
  localparam logic [7:0] ADDR_DIV_A0    = 8'h08;
  localparam logic [7:0] ADDR_DIV_A1    = 8'h09;
  localparam logic [7:0] ADDR_DIV_B0    = 8'h0A;
  localparam logic [7:0] ADDR_DIV_B1    = 8'h0B;
  localparam logic [7:0] ADDR_DIV_C     = 8'h0C;
  localparam logic [7:0] ADDR_DIV_D     = 8'h0D;
  localparam logic [7:0] ADDR_SRC_AB    = 8'h0E;
  localparam logic [7:0] ADDR_SRC_CD    = 8'h0F;
  localparam logic [7:0] ADDR_PLL2_Q    = 8'h10;
  localparam logic [7:0] ADDR_PLL2_PLO  = 8'h11;
  localparam logic [7:0] ADDR_PLL2_PHI  = 8'h12;
  localparam logic [7:0] ADDR_PLL3_Q    = 8'h14;
  localparam logic [7:0] ADDR_PLL3_PLO  = 8'h15;
  localparam logic [7:0] ADDR_PLL3_PHI  = 8'h16;
  localparam logic [7:0] ADDR_CTRL      = 8'h18;
  localparam logic [7:0] ADDR_XCAP      = 8'h19;
  localparam logic [7:0] ADDR_SUSP_MASK = 8'h1A;
  localparam logic [7:0] ADDR_OUT_DIS   = 8'h1B;
  localparam logic [7:0] ADDR_STATUS    = 8'h1C;
  // Frequency table: 0x40 + row*4 + byte (0 = Q, 1 = P low, 2 = select/P high)
  localparam logic [2:0] ADDR_TBL_TOP   = 3'h2;
  localparam logic [1:0] TBL_BYTE_Q     = 2'h0;
  localparam logic [1:0] TBL_BYTE_PLO   = 2'h1;
  localparam logic [1:0] TBL_BYTE_PHI   = 2'h2;

  // Field positions
  localparam int CTRL_SD_FUNC   = 0;
  localparam int CTRL_SUSP_MODE = 1;
  localparam int CTRL_PLL_EN0   = 2;
  localparam int CTRL_E_DIV_LO  = 5;
  localparam int PHI_SEL_BIT    = 7;
  localparam int SUSP_OUT0      = 3;

  // Reset values
  localparam logic [7:0] CTRL_RST      = 8'h01;
  localparam logic [5:0] XCAP_RST      = 6'h00;
  localparam logic [7:0] SUSP_RST      = 8'h00;
  localparam logic [4:0] OUT_DIS_RST   = 5'h00;
  localparam logic [6:0] DIV_RST       = 7'h00;
  localparam logic [2:0] FS_RST        = 3'h0;
  localparam logic [7:0] RDATA_UNMAP   = 8'h00;

  // Output source codes
  localparam logic [2:0] FS_REF  = 3'h0;
  localparam logic [2:0] FS_RSVD = 3'h1;

  // Output E post-divider codes and their moduli
  localparam logic [1:0] E_OFF   = 2'h0;
  localparam logic [1:0] E_DIV4  = 2'h1;
  localparam logic [1:0] E_DIV2  = 2'h2;
  localparam logic [1:0] E_DIV3  = 2'h3;
  localparam logic [1:0] E_MOD4  = 2'h3;
  localparam logic [1:0] E_MOD2  = 2'h1;
  localparam logic [1:0] E_MOD3  = 2'h2;

  typedef struct packed {
    logic        en;
    logic [10:0] p;
    logic [7:0]  q;
  } pll_cfg_t;

  typedef struct packed {
    logic        ab_divider_register_select;
    logic [10:0] p;
    logic [7:0]  q;
  } row_t;

  typedef struct packed {
    row_t     [7:0]      tbl;
    pll_cfg_t [1:0]      pll23;
    logic     [5:0][6:0] div;
    logic     [3:0][2:0] fs;
    logic     [7:0]      ctrl;
    logic     [5:0]      xcap;
    logic     [7:0]      susp;
    logic     [4:0]      out_dis;
    logic     [1:0]      strap;
    logic                strap_done;
    logic     [1:0]      ab_sel;
    logic     [3:0][6:0] cnt;
    logic     [1:0]      ecnt;
    pll_cfg_t [2:0]      pll_o;
    logic     [5:0]      xcap_o;
    logic                osc_run;
    logic     [4:0]      clk;
    logic     [4:0]      oe;
    logic     [7:0]      rdata;
    logic     [2:0]      row_o;
  } state_t;

endpackage : clk_cfg_pkg

// file: bench/clock_config_ctrl_sva.sv
// Port-level checks of the clock configuration block.
// Assumes one clock domain; bound from the bench top.
`timescale 1ns/10ps
module clock_config_ctrl_sva
  import clk_cfg_pkg::*;
(
  input wire logic           sys_clk_i,
  input wire logic           sys_rst_i,
  input wire logic     [7:0] reg_addr_i,
  input wire logic     [7:0] reg_wdata_i,
  input wire logic           reg_wr_i,
  input wire logic           reg_rd_i,
  input wire logic     [7:0] reg_rdata_o,
  input wire logic           shutdown_oe_i,
  input wire pll_cfg_t [2:0] pll_cfg_o,
  input wire logic     [5:0] crystal_load_code_o,
  input wire logic           osc_run_o,
  input wire logic     [4:0] clk_out_o,
  input wire logic     [4:0] clk_oe_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_RDATA_ONLY_AFTER_READ: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside its answer cycle");
  AST_LOAD_CODE_WRITE: assert property (reg_wr_i && reg_addr_i == ADDR_XCAP
    |-> ##2 crystal_load_code_o == $past(reg_wdata_i[5:0], 2)) else $error("load code not applied");
  AST_LOAD_CODE_HOLD: assert property (!$past(reg_wr_i) && !$past(reg_wr_i, 2)
    |-> $stable(crystal_load_code_o)) else $error("load code moved without a write");
  AST_PLL2_Q_BYTE: assert property (reg_wr_i && reg_addr_i == ADDR_PLL2_Q
    |-> ##2 pll_cfg_o[1].q == $past(reg_wdata_i, 2)) else $error("pll2 q byte not applied");
  AST_PLL2_SERIAL_ONLY: assert property (!$past(reg_wr_i) && !$past(reg_wr_i, 2)
    |-> $stable(pll_cfg_o[1].p) && $stable(pll_cfg_o[1].q)) else $error("pll2 moved without a write");
  AST_PIN_LOW_TRISTATE: assert property (!shutdown_oe_i [*3] |-> clk_oe_o == 5'h00)
    else $error("outputs driven with shutdown pin low");
  AST_OSC_STOP_CAUSE: assert property ($fell(osc_run_o) |-> !$past(shutdown_oe_i))
    else $error("oscillator stopped with pin high");
  AST_SHUTDOWN_QUIET: assert property (!osc_run_o |-> clk_oe_o == 5'h00
    && !pll_cfg_o[0].en && !pll_cfg_o[1].en && !pll_cfg_o[2].en) else $error("activity in full shutdown");

  cover property (reg_rd_i ##1 reg_rdata_o != 8'h00);
  cover property ($fell(osc_run_o));
  cover property ($rose(clk_out_o[4]));
endmodule : clock_config_ctrl_sva

// file: bench/host_model.sv
// Host side of the register port: single-cycle writes and reads.
// Assumes the slave never stalls; read data stands one cycle after the strobe.
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o  = 8'h00,
  output logic      [7:0] wdata_o = 8'h00,
  output logic            wr_o    = 1'b0,
  output logic            rd_o    = 1'b0
);
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask : rd_reg
endmodule : host_model

// file: bench/clock_config_ctrl_tb.sv
// Self-checking bench for the clock configuration block.
// Assumes every source ticks each cycle, so a divide by n gives one rise per n cycles.
`timescale 1ns/10ps
module clock_config_ctrl_tb;
  import clk_cfg_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sel0 = 1'b1, sel1 = 1'b0, sel2 = 1'b0, shdn_n = 1'b1;
  logic [3:0] tick = 4'hF;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, osc_run;
  pll_cfg_t [2:0] pll_cfg;
  logic [5:0] load_code;
  logic [4:0] clk_out, clk_oe;
  logic [2:0] row;
  int miscompares = 0;
  int checks = 0;
  always #50 sys_clk_i = ~sys_clk_i;

  host_model host (.clk_i(sys_clk_i), .rdata_i(reg_rdata), .addr_o(reg_addr), .wdata_o(reg_wdata),
    .wr_o(reg_wr), .rd_o(reg_rd));
  clock_config_ctrl dut (.sys_clk_i, .sys_rst_i, .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .freq_select_bit0_i(sel0),
    .freq_select_bit1_i(sel1), .freq_select_bit2_i(sel2), .shutdown_oe_i(shdn_n), .src_tick_i(tick),
    .pll_cfg_o(pll_cfg), .crystal_load_code_o(load_code), .osc_run_o(osc_run), .clk_out_o(clk_out),
    .clk_oe_o(clk_oe), .table_row_o(row));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc

  // Settle, then count rising edges of one output over 24 cycles
  task automatic chk_rate(input string what, input int b, input int exp);
    int n;
    logic p;
    n = 0;
    cyc(4);
    p = clk_out[b];
    repeat (24) begin
      cyc(1);
      if (clk_out[b] === 1'b1 && p === 1'b0) n++;
      p = clk_out[b];
    end
    chk(what, exp, n);
  endtask : chk_rate

  task automatic t_table();
    chk("strap row", 3'h1, row);
    @(posedge sys_clk_i) sel0 <= 1'b0;
    host.wr_reg(8'h44, 8'h11);
    host.wr_reg(8'h54, 8'h55);
    host.wr_reg(8'h56, 8'h80);
    host.wr_reg(ADDR_DIV_A0, 8'h04);
    host.wr_reg(ADDR_DIV_A1, 8'h02); // idle set loaded before switching to it
    host.wr_reg(ADDR_CTRL, 8'h05);
    chk_rate("a via reg0", 0, 6);
    chk("only a driven", 5'h01, clk_oe);
    chk("row kept strap", 3'h1, row);
    chk("pll1 q row1", 8'h11, pll_cfg[0].q);
    @(posedge sys_clk_i) sel2 <= 1'b1;
    chk_rate("a via reg1", 0, 12);
    chk("row with s2", 3'h5, row);
    chk("pll1 q row5", 8'h55, pll_cfg[0].q);
    host.wr_reg(ADDR_SRC_AB, {5'h00, FS_RSVD});
    chk_rate("a reserved", 0, 0);
    host.wr_reg(ADDR_SRC_AB, 8'h02);
    chk_rate("a from pll1", 0, 12);
  endtask : t_table

  task automatic t_load();
    logic [7:0] d;
    host.wr_reg(ADDR_XCAP, 8'h3F);
    cyc(2);
    chk("load code", 8'h3F, load_code);
    host.wr_reg(ADDR_XCAP, 8'h15);
    host.rd_reg(ADDR_XCAP, d);
    chk("load live", 8'h15, load_code);
    chk("load readback", 8'h15, d);
    host.rd_reg(8'h05, d);
    chk("unmapped read", 8'h00, d);
  endtask : t_load

  task automatic t_pll2();
    host.wr_reg(ADDR_CTRL, 8'h01); // PLL held off during the update
    host.wr_reg(ADDR_PLL2_Q, 8'hA5);
    cyc(2);
    chk("q byte", {1'b0, 11'h000, 8'hA5}, pll_cfg[1]);
    host.wr_reg(ADDR_PLL2_PLO, 8'h3C);
    cyc(2);
    chk("p low byte", {1'b0, 11'h03C, 8'hA5}, pll_cfg[1]);
    host.wr_reg(ADDR_PLL2_PHI, 8'h05);
    host.wr_reg(ADDR_CTRL, 8'h09); // re-enabled once all bytes are
    cyc(2);
    chk("pll2 on", {1'b1, 11'h53C, 8'hA5}, pll_cfg[1]);
    chk("pll1 left off", 1'b0, pll_cfg[0].en);
  endtask : t_pll2

  task automatic t_shutdown();
    logic [7:0] d;
    @(posedge sys_clk_i) shdn_n <= 1'b0;
    cyc(3);
    chk("osc stopped", 1'b0, osc_run);
    chk("pll2 stopped", 1'b0, pll_cfg[1].en);
    host.wr_reg(ADDR_XCAP, 8'h2A);
    host.rd_reg(ADDR_XCAP, d);
    chk("port in shutdown", 8'h2A, d);
    host.wr_reg(ADDR_CTRL, 8'h08);
    cyc(3);
    chk("osc as oe pin", 1'b1, osc_run);
    chk("oe pin low", 5'h00, clk_oe);
    @(posedge sys_clk_i) shdn_n <= 1'b1;
  endtask : t_shutdown

  task automatic t_out_e();
    int exp [4] = '{0, 6, 12, 8};
    for (int c = 0; c < 4; c++) begin
      host.wr_reg(ADDR_CTRL, {1'b0, c[1:0], 5'h05});
      chk_rate("e rate", 4, exp[c]);
    end
  endtask : t_out_e

  // Suspend mode: third pin low stops PLL1 and output A, pin no longer indexes
  task automatic t_suspend();
    host.wr_reg(ADDR_SUSP_MASK, 8'h09);
    host.wr_reg(ADDR_CTRL, 8'h07);
    chk_rate("a in suspend mode", 0, 6);
    chk("row in suspend mode", 3'h1, row);
    @(posedge sys_clk_i) sel2 <= 1'b0;
    cyc(3);
    chk("pll1 suspended", 1'b0, pll_cfg[0].en);
    chk("outputs off in suspend", 5'h00, clk_oe);
    chk_rate("a stopped", 0, 0);
    @(posedge sys_clk_i) sel2 <= 1'b1;
    chk_rate("a resumed", 0, 6);
    chk("a driven again", 5'h01, clk_oe);
    host.wr_reg(ADDR_OUT_DIS, 8'h01);
    cyc(2);
    chk("a disabled", 5'h00, clk_oe);
  endtask : t_suspend

  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    cyc(3);
    t_table();
    $display("test table done");
    t_load();
    $display("test load done");
    t_pll2();
    $display("test pll2 done");
    t_shutdown();
    $display("test shutdown done");
    t_out_e();
    $display("test output e done");
    t_suspend();
    $display("test suspend done");
    summarize();
  end
endmodule : clock_config_ctrl_tb

bind clock_config_ctrl clock_config_ctrl_sva chk_i (.sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .shutdown_oe_i, .pll_cfg_o, .crystal_load_code_o, .osc_run_o,
  .clk_out_o, .clk_oe_o);
